// [bfpb_port_b.sv]
/*
  Port B control of a bidirectional bus-matching FIFO pair, with
  a Wishbone register slave standing in for the Port A side.
  Assumes Port B pins and the Port B clock are synchronous to clk.
*/
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module bfpb_port_b #(
  parameter int unsigned FIFO_AW = 9
) (
  // Clock and device reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port B data
  input wire logic [7:0] port_b_data_i,
  input wire logic port_b_parity_bit_i,
  output logic [7:0] port_b_data_o,
  output logic port_b_parity_bit_o,
  output logic port_b_data_oe,
  // Port B strobes: read or data strobe, write strobe or direction
  input wire logic port_b_read_strobe_n_i,
  output logic port_b_read_strobe_n_o,
  output logic port_b_read_strobe_n_oe,
  input wire logic port_b_write_strobe_n_i,
  output logic port_b_write_strobe_n_o,
  output logic port_b_write_strobe_n_oe,
  // Peripheral handshake
  input wire logic port_b_request_i,
  output logic port_b_ack_o,
  input wire logic port_b_clk_i,
  // Pointer reloads and flags
  input wire logic reread_input_n,
  input wire logic rewrite_input_n,
  output logic [3:0] flag_outputs
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam logic [FIFO_AW:0] PTR_ZERO = '0;
  bfpb_pkg::bfpb_cfg_t cfg_reg, cfg_next;
  logic [12:0] fsel_reg, fsel_next;
  logic [31:0] lvl_reg, lvl_next;
  logic [31:0] rdat_reg, rdat_next;
  logic ack_reg, ack_next;
  logic [31:0] reg_rd, wr_word;
  logic bus_req, soft_rst, clr_par, ab_push, ba_pop;
  bfpb_pkg::bfpb_state_t pst_reg, pst_next;
  logic half_out_reg, half_out_next, half_in_reg, half_in_next;
  logic [8:0] hold_reg, hold_next, dout_reg, dout_next;
  logic doe_reg, doe_next, pack_reg, pack_next, perr_reg, perr_next;
  logic [1:0] slot_reg, slot_next;
  logic rso_reg, rso_next, wso_reg, wso_next, soe_reg, soe_next;
  logic acko_reg, acko_next;
  logic rs_prev_reg, ws_prev_reg, ck_prev_reg;
  logic [FIFO_AW:0] rr_ptr_reg, rr_ptr_next, rw_ptr_reg, rw_ptr_next;
  logic [3:0] flags_reg, flags_next, flag_mux;
  logic ab_pop, ba_push, ev_out, ev_in, drive, mine, ready, req_act;
  logic rd_ev, wr_ev, rs_rise, ck_rise;
  logic [8:0] in_byte, out_byte;
  logic [17:0] ab_dout, ba_dout;
  logic [FIFO_AW:0] ab_rd_ptr, ab_wr_ptr, ba_rd_ptr, ba_wr_ptr;
  logic [3:0] ab_flags, ba_flags;

  // Byte-lane merge for register writes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = sel[b] ? wdat[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ----------------------------------------
  // FIFO pair
  // ----------------------------------------
  // Two independent arrays, so both directions run concurrently.
  bfpb_fifo #(.W(bfpb_pkg::WORD_W), .AW(FIFO_AW)) u_ab (
    .clk(clk),
    .rst_n(rst_n),
    .clr(soft_rst),
    .push(ab_push),
    .din(wb_dat_i[17:0]),
    .pop(ab_pop),
    .dout(ab_dout),
    .load_rd(!reread_input_n),
    .rd_val(rr_ptr_reg),
    .load_wr(1'b0),
    .wr_val(PTR_ZERO),
    .rd_ptr(ab_rd_ptr),
    .wr_ptr(ab_wr_ptr),
    .ae_off(lvl_reg[FIFO_AW-1:0]),
    .af_off(lvl_reg[bfpb_pkg::LVL_AF_POS +: FIFO_AW]),
    .flags(ab_flags)
  );

  bfpb_fifo #(.W(bfpb_pkg::WORD_W), .AW(FIFO_AW)) u_ba (
    .clk(clk),
    .rst_n(rst_n),
    .clr(soft_rst),
    .push(ba_push),
    .din({in_byte, hold_reg}),
    .pop(ba_pop),
    .dout(ba_dout),
    .load_rd(1'b0),
    .rd_val(PTR_ZERO),
    .load_wr(!rewrite_input_n),
    .wr_val(rw_ptr_reg),
    .rd_ptr(ba_rd_ptr),
    .wr_ptr(ba_wr_ptr),
    .ae_off(lvl_reg[FIFO_AW-1:0]),
    .af_off(lvl_reg[bfpb_pkg::LVL_AF_POS +: FIFO_AW]),
    .flags(ba_flags)
  );

  bfpb_flag_sel u_flags (
    .int_flags({ba_flags, ab_flags}),
    .sel(fsel_reg[11:0]),
    .par_on_a(fsel_reg[bfpb_pkg::FS_PAR] & cfg_reg.par_chk),
    .par_err(perr_reg),
    .pins(flag_mux)
  );

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;

  // Read view of the addressed register; writes merge into it.
  always_comb begin
    case (wb_adr_i)
      bfpb_pkg::OFS_DATA: reg_rd = {14'h0000, ba_dout};
      bfpb_pkg::OFS_CONFIG: reg_rd = {19'h00000, cfg_reg};
      bfpb_pkg::OFS_FLAGSEL: reg_rd = {19'h00000, fsel_reg};
      bfpb_pkg::OFS_CMD: reg_rd = {20'h00000, slot_reg, pst_reg != bfpb_pkg::PB_IDLE,
                                   perr_reg, ba_flags, ab_flags};
      bfpb_pkg::OFS_LEVEL: reg_rd = lvl_reg;
      default: reg_rd = 32'h0000_0000;
    endcase
    wr_word = merge(reg_rd, wb_dat_i, wb_sel_i);
  end

  // Each access is answered one cycle after it appears; side
  // effects happen in that same cycle so they occur exactly once.
  always_comb begin
    ack_next = bus_req;
    rdat_next = rdat_reg;
    cfg_next = cfg_reg;
    fsel_next = fsel_reg;
    lvl_next = lvl_reg;
    soft_rst = 1'b0;
    clr_par = 1'b0;
    ab_push = 1'b0;
    ba_pop = 1'b0;
    if (bus_req) begin
      rdat_next = wb_we_i ? 32'h0000_0000 : reg_rd;
      if (wb_we_i) begin
        case (wb_adr_i)
          bfpb_pkg::OFS_DATA: ab_push = ~ab_flags[3];
          bfpb_pkg::OFS_CONFIG: cfg_next = wr_word[12:0];
          bfpb_pkg::OFS_FLAGSEL: fsel_next = wr_word[12:0];
          bfpb_pkg::OFS_CMD: begin
            soft_rst = wb_sel_i[0] & wb_dat_i[bfpb_pkg::CMD_SOFT_RST];
            clr_par = wb_sel_i[0] & wb_dat_i[bfpb_pkg::CMD_CLR_PAR];
          end
          bfpb_pkg::OFS_LEVEL: lvl_next = wr_word;
          default: ;
        endcase
      end else if (wb_adr_i == bfpb_pkg::OFS_DATA) begin
        ba_pop = ~ba_flags[0];
      end
    end
  end

  // Configuration survives a software reset; only the pin clears it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      cfg_reg <= bfpb_pkg::CONFIG_RST;
      fsel_reg <= bfpb_pkg::FLAGSEL_RST;
      lvl_reg <= bfpb_pkg::LEVEL_RST;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      cfg_reg <= cfg_next;
      fsel_reg <= fsel_next;
      lvl_reg <= lvl_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ----------------------------------------
  // Port B engine
  // ----------------------------------------
  // The slave of a pair only follows the master's strobes.
  assign drive = cfg_reg.periph & (cfg_reg.bus_cfg != bfpb_pkg::BUS_SLAVE);
  assign mine = (cfg_reg.bus_cfg == bfpb_pkg::BUS_SLAVE) ? ~slot_reg[1] :
                (cfg_reg.bus_cfg == bfpb_pkg::BUS_MASTER) ? slot_reg[1] : 1'b1;
  assign req_act = port_b_request_i ~^ cfg_reg.req_pol;
  assign ready = ~mine | (cfg_reg.dma_out ? ~ab_flags[0] : ~ba_flags[3]);
  assign ck_rise = port_b_clk_i & ~ck_prev_reg;
  assign rs_rise = port_b_read_strobe_n_i & ~rs_prev_reg;
  assign in_byte = {port_b_parity_bit_i, port_b_data_i};

  // Strobe edges seen from the far side.
  always_comb begin
    if (cfg_reg.combined) begin
      rd_ev = ~port_b_read_strobe_n_i & rs_prev_reg & port_b_write_strobe_n_i;
      wr_ev = rs_rise & ~port_b_write_strobe_n_i;
    end else begin
      rd_ev = ~port_b_read_strobe_n_i & rs_prev_reg;
      wr_ev = port_b_write_strobe_n_i & ~ws_prev_reg;
    end
  end

  // Low byte first, high byte second; parity replaces bit 8.
  always_comb begin
    out_byte = half_out_reg ? ab_dout[17:9] : ab_dout[8:0];
    if (cfg_reg.par_gen) begin
      out_byte[8] = ^out_byte[7:0];
    end
  end

  // Transfer sequencing, byte pairing and pin drive.
  always_comb begin
    pst_next = pst_reg;
    half_out_next = half_out_reg;
    half_in_next = half_in_reg;
    hold_next = hold_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    pack_next = pack_reg;
    slot_next = slot_reg;
    rso_next = 1'b1;
    wso_next = 1'b1;
    soe_next = drive;
    ev_out = 1'b0;
    ev_in = 1'b0;
    ab_pop = 1'b0;
    ba_push = 1'b0;
    if (drive) begin
      if (cfg_reg.combined) begin
        wso_next = ~cfg_reg.dma_out;
      end
      // Every step waits for a Port B clock edge.
      unique case (pst_reg)
        bfpb_pkg::PB_IDLE: begin
          if (ck_rise && req_act && ready) begin
            pst_next = bfpb_pkg::PB_ACK;
            pack_next = 1'b1;
            ev_out = cfg_reg.dma_out;
          end
        end
        bfpb_pkg::PB_ACK: begin
          if (ck_rise) begin
            pst_next = bfpb_pkg::PB_STROBE;
          end
        end
        bfpb_pkg::PB_STROBE: begin
          if (cfg_reg.combined || !cfg_reg.dma_out) begin
            rso_next = ~ck_rise;
          end else begin
            wso_next = ~ck_rise;
          end
          if (ck_rise) begin
            pst_next = bfpb_pkg::PB_RELEASE;
            ev_in = ~cfg_reg.dma_out;
          end
        end
        bfpb_pkg::PB_RELEASE: begin
          if (cfg_reg.combined || !cfg_reg.dma_out) begin
            rso_next = ~ck_rise;
          end else begin
            wso_next = ~ck_rise;
          end
          if (ck_rise) begin
            pst_next = bfpb_pkg::PB_IDLE;
            pack_next = 1'b0;
            doe_next = 1'b0;
          end
        end
      endcase
      // Strobe output mirrors the cycle the sequencer sits in.
      if (pst_next != bfpb_pkg::PB_STROBE && pst_next != bfpb_pkg::PB_RELEASE) begin
        rso_next = 1'b1;
        wso_next = cfg_reg.combined ? ~cfg_reg.dma_out : 1'b1;
      end else if (cfg_reg.combined || !cfg_reg.dma_out) begin
        rso_next = pst_next != bfpb_pkg::PB_STROBE;
      end else begin
        wso_next = pst_next != bfpb_pkg::PB_STROBE;
      end
    end else begin
      pst_next = bfpb_pkg::PB_IDLE;
      pack_next = 1'b0;
      ev_out = rd_ev;
      ev_in = wr_ev;
      if (rs_rise) begin
        doe_next = 1'b0;
      end
    end
    // Present a byte; the word is popped after its second byte.
    if (ev_out && mine) begin
      dout_next = ab_flags[0] ? 9'h000 : out_byte;
      doe_next = 1'b1;
      if (!ab_flags[0]) begin
        ab_pop = half_out_reg;
        half_out_next = ~half_out_reg;
      end
    end
    // Take a byte; the second one completes and pushes the word.
    if (ev_in && mine) begin
      if (half_in_reg) begin
        ba_push = ~ba_flags[3];
      end else begin
        hold_next = in_byte;
      end
      half_in_next = ~half_in_reg;
    end
    if (ev_out || ev_in) begin
      slot_next = slot_reg + 2'h1;
    end
    if (soft_rst) begin
      pst_next = bfpb_pkg::PB_IDLE;
      half_out_next = 1'b0;
      half_in_next = 1'b0;
      slot_next = 2'h0;
      doe_next = 1'b0;
      pack_next = 1'b0;
    end
    acko_next = pack_next ~^ cfg_reg.ack_pol;
  end

  // Parity error is sticky; a new error beats a clear.
  always_comb begin
    perr_next = perr_reg & ~clr_par & ~soft_rst;
    if (ev_in && mine && cfg_reg.par_chk && (in_byte[8] != ^in_byte[7:0])) begin
      perr_next = 1'b1;
    end
    rr_ptr_next = cfg_reg.save_rd ? ab_rd_ptr : rr_ptr_reg;
    rw_ptr_next = cfg_reg.save_wr ? ba_wr_ptr : rw_ptr_reg;
    flags_next = flag_mux;
  end

  // Port B registers; every pin output comes from here.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pst_reg <= bfpb_pkg::PB_IDLE;
      half_out_reg <= 1'b0;
      half_in_reg <= 1'b0;
      hold_reg <= 9'h000;
      dout_reg <= 9'h000;
      doe_reg <= 1'b0;
      pack_reg <= 1'b0;
      slot_reg <= 2'h0;
      rso_reg <= 1'b1;
      wso_reg <= 1'b1;
      soe_reg <= 1'b0;
      acko_reg <= 1'b1;
      perr_reg <= 1'b0;
      rs_prev_reg <= 1'b1;
      ws_prev_reg <= 1'b1;
      ck_prev_reg <= 1'b0;
      rr_ptr_reg <= '0;
      rw_ptr_reg <= '0;
      flags_reg <= 4'h0;
    end else begin
      pst_reg <= pst_next;
      half_out_reg <= half_out_next;
      half_in_reg <= half_in_next;
      hold_reg <= hold_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      pack_reg <= pack_next;
      slot_reg <= slot_next;
      rso_reg <= rso_next;
      wso_reg <= wso_next;
      soe_reg <= soe_next;
      acko_reg <= acko_next;
      perr_reg <= perr_next;
      rs_prev_reg <= port_b_read_strobe_n_i;
      ws_prev_reg <= port_b_write_strobe_n_i;
      ck_prev_reg <= port_b_clk_i;
      rr_ptr_reg <= rr_ptr_next;
      rw_ptr_reg <= rw_ptr_next;
      flags_reg <= flags_next;
    end
  end

  assign port_b_data_o = dout_reg[7:0];
  assign port_b_parity_bit_o = dout_reg[8];
  assign port_b_data_oe = doe_reg;
  assign port_b_read_strobe_n_o = rso_reg;
  assign port_b_write_strobe_n_o = wso_reg;
  assign port_b_read_strobe_n_oe = soe_reg;
  assign port_b_write_strobe_n_oe = soe_reg;
  assign port_b_ack_o = acko_reg;
  assign flag_outputs = flags_reg;
endmodule
`default_nettype wire

// [bfpb_pkg.sv]
/*
  Shared constants and types for the Port B control block.
  Assumes a 32-bit classic Wishbone register bus and one clock.
*/
`default_nettype none
package bfpb_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned WORD_W = 18;
  localparam int unsigned BYTE_W = 9;
  localparam int unsigned FS_W = 3;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_FLAGSEL = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_LEVEL = 8'h10;

  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam logic [1:0] BUS_ALONE = 2'h0;
  localparam logic [1:0] BUS_SLAVE = 2'h2;
  localparam logic [1:0] BUS_MASTER = 2'h3;
  localparam int unsigned CMD_SOFT_RST = 0;
  localparam int unsigned CMD_CLR_PAR = 1;
  localparam int unsigned FS_PAR = 12;
  localparam int unsigned LVL_AF_POS = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [12:0] CONFIG_RST = 13'h0000;
  localparam logic [12:0] FLAGSEL_RST = 13'h0F18;
  localparam logic [31:0] LEVEL_RST = 32'h0008_0008;

  // Configuration word; each field sits at its bit position.
  typedef struct packed {
    logic [1:0] bus_cfg;
    logic periph;
    logic [1:0] spare;
    logic save_wr;
    logic save_rd;
    logic dma_out;
    logic par_chk;
    logic par_gen;
    logic ack_pol;
    logic req_pol;
    logic combined;
  } bfpb_cfg_t;

  // Peripheral-mode transfer sequence.
  typedef enum {PB_IDLE, PB_ACK, PB_STROBE, PB_RELEASE} bfpb_state_t;

endpackage
`default_nettype wire

// [bfpb_fifo.sv]
/*
  One direction of the FIFO pair with reloadable pointers and flags.
  Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/10ps
`default_nettype none
module bfpb_fifo #(
  parameter int unsigned W = 18,
  parameter int unsigned AW = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  // Pointer reloads
  input wire logic load_rd,
  input wire logic [AW:0] rd_val,
  input wire logic load_wr,
  input wire logic [AW:0] wr_val,
  output logic [AW:0] rd_ptr,
  output logic [AW:0] wr_ptr,
  // Flags: full, almost-full, almost-empty, empty
  input wire logic [AW-1:0] ae_off,
  input wire logic [AW-1:0] af_off,
  output logic [3:0] flags
);
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  logic [W-1:0] mem [2**AW];
  logic [AW:0] rd_next;
  logic [AW:0] wr_next;
  logic [AW:0] level;

  // A reload overrides a step in the same cycle.
  always_comb begin
    rd_next = pop ? rd_ptr + 1'b1 : rd_ptr;
    wr_next = push ? wr_ptr + 1'b1 : wr_ptr;
    if (load_rd) begin
      rd_next = rd_val;
    end
    if (load_wr) begin
      wr_next = wr_val;
    end
    if (clr) begin
      rd_next = '0;
      wr_next = '0;
    end
  end

  // Pointer registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
    end else begin
      rd_ptr <= rd_next;
      wr_ptr <= wr_next;
    end
  end

  // Storage has no reset, so it maps onto plain RAM.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= din;
    end
  end

  assign dout = mem[rd_ptr[AW-1:0]];
  assign level = wr_ptr - rd_ptr;
  assign flags = {level == DEPTH, level >= DEPTH - {1'b0, af_off},
                  level <= {1'b0, ae_off}, level == '0};
endmodule
`default_nettype wire

// [bfpb_flag_sel.sv]
/*
  Routes any of eight internal flags onto each of four flag pins.
  Assumes the parity choice for the first pin is already gated.
*/
`timescale 1ns/10ps
`default_nettype none
module bfpb_flag_sel (
  // Sources
  input wire logic [7:0] int_flags,
  input wire logic [11:0] sel,
  input wire logic par_on_a,
  input wire logic par_err,
  // Result
  output logic [3:0] pins
);
  logic [3:0] raw;

  // One selector per pin.
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      assign raw[i] = int_flags[sel[i*3 +: 3]];
    end
  endgenerate

  assign pins = {raw[3:1], par_on_a ? par_err : raw[0]};
endmodule
`default_nettype wire

// [bfpb_props.sv]
/*
  Checker for the Port B control block, bound to its top module.
  Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module bfpb_props #(
  parameter int unsigned FIFO_AW = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Port B
  input wire logic port_b_data_oe,
  input wire logic port_b_read_strobe_n_i,
  input wire logic port_b_read_strobe_n_oe,
  input wire logic port_b_write_strobe_n_o,
  input wire logic port_b_write_strobe_n_oe,
  input wire logic port_b_clk_i
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] pk;
  // History of Port B clock samples; a short window keeps the check sharp.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pk <= 4'h0;
    end else begin
      pk <= {pk[2:0], port_b_clk_i};
    end
  end
  // ----------
  // Properties
  // ----------
  // A read strobe fall seen while the strobe is an input.
  sequence s_rd_edge;
    $fell(port_b_read_strobe_n_i) && !port_b_read_strobe_n_oe;
  endsequence
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Wishbone request not answered.");
  ack_pulse_a: assert property (wb_ack_o |-> $past(wb_stb_i) ##1 !wb_ack_o)
    else $error("Wishbone ack not a single pulse.");
  unmapped_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h10 |-> wb_dat_o == 32'h0)
    else $error("Unmapped read not zero.");
  rst_inputs_a: assert property ($rose(rst_n) |-> !port_b_read_strobe_n_oe && !port_b_write_strobe_n_oe)
    else $error("Strobes driven after reset.");
  oe_pair_a: assert property (port_b_read_strobe_n_oe == port_b_write_strobe_n_oe)
    else $error("Strobe directions differ.");
  rd_answer_a: assert property (s_rd_edge |-> ##[1:3] port_b_data_oe)
    else $error("Read strobe fall not answered.");
  oe_cause_a: assert property ($rose(port_b_data_oe) && !port_b_read_strobe_n_oe |->
    !$past(port_b_read_strobe_n_i)) else $error("Data driven without read strobe.");
  strobe_clk_a: assert property ($changed(port_b_write_strobe_n_o) && $past(port_b_write_strobe_n_oe)
    |-> |(pk[2:0] & ~pk[3:1])) else $error("Strobe moved away from Port B clock rise.");
endmodule
`default_nettype wire

// [bfpb_peer.sv]
/*
  Port B partner: second processor, or peripheral with request.
  Assumes the bench resolves the shared lines it hands in.
*/
`timescale 1ns/10ps
`default_nettype none
module bfpb_peer (
  // Clock
  input wire logic clk,
  // Resolved lines
  input wire logic [8:0] bus,
  input wire logic ws_line,
  // Driven lines
  output logic rs_n,
  output logic ws_n,
  output logic [8:0] dat,
  output logic req,
  output logic pclk
);
  logic run, ws_q;
  logic [1:0] pdiv;
  logic [17:0] cap;
  initial begin
    {rs_n, ws_n, req, pclk, run, ws_q, pdiv, dat} = 17'h18000;
  end
  // Port B clock runs only while a transfer is wanted; bytes land at write strobe rise.
  always @(posedge clk) begin
    ws_q <= ws_line;
    pdiv <= pdiv + 2'h1;
    if (run && pdiv == 2'h3) pclk <= ~pclk;
    if (ws_line && !ws_q) cap <= {bus, cap[17:9]};
  end
  task automatic go(input logic r);
    @(posedge clk);
    run <= r;
    req <= r;
  endtask
  // Released data shows the inverse of the last byte, never a stale copy.
  task automatic pb_rd(output logic [8:0] v);
    @(posedge clk);
    rs_n <= 1'b0;
    repeat (4) @(posedge clk);
    v = bus;
    rs_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic pb_wr(input logic [8:0] v);
    @(posedge clk);
    dat <= v;
    ws_n <= 1'b0;
    repeat (3) @(posedge clk);
    ws_n <= 1'b1;
    repeat (2) @(posedge clk);
    dat <= ~v;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
/*
  Bench for the Port B control block: Wishbone tasks and a Port B partner.
  Assumes the 20 MHz clock and Port B lines with pull-ups.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, port_b_parity_bit_o, port_b_data_oe;
  logic [7:0] wb_adr_i, port_b_data_o;
  logic [3:0] wb_sel_i, flag_outputs;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic port_b_read_strobe_n_o, port_b_read_strobe_n_oe, port_b_write_strobe_n_o, port_b_write_strobe_n_oe;
  logic port_b_ack_o, reread_input_n, rewrite_input_n, p_rs, p_ws, p_req, p_clk;
  logic [8:0] p_dat, b;
  wire [8:0] bus;
  wire rs_line, ws_line;
  int n_fail, compares, n;
  // A driving end wins each shared line; otherwise the partner's level shows.
  assign bus = port_b_data_oe ? {port_b_parity_bit_o, port_b_data_o} : p_dat;
  assign rs_line = port_b_read_strobe_n_oe ? port_b_read_strobe_n_o : p_rs;
  assign ws_line = port_b_write_strobe_n_oe ? port_b_write_strobe_n_o : p_ws;
  bfpb_port_b #(.FIFO_AW(4)) dut_u (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_b_data_i(bus[7:0]), .port_b_parity_bit_i(bus[8]),
    .port_b_data_o, .port_b_parity_bit_o, .port_b_data_oe, .port_b_read_strobe_n_i(rs_line),
    .port_b_read_strobe_n_o, .port_b_read_strobe_n_oe, .port_b_write_strobe_n_i(ws_line),
    .port_b_write_strobe_n_o, .port_b_write_strobe_n_oe, .port_b_request_i(p_req), .port_b_ack_o,
    .port_b_clk_i(p_clk), .reread_input_n, .rewrite_input_n, .flag_outputs);
  bfpb_peer peer_u (.clk, .bus, .ws_line, .rs_n(p_rs), .ws_n(p_ws), .dat(p_dat), .req(p_req), .pclk(p_clk));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------
  // Tasks
  // ----------
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic guard(input int bound);
    if (n >= bound) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // Classic single cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    guard(20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask
  task automatic fl(input logic [3:0] exp);
    @(negedge clk);
    chk("flags", flag_outputs, exp);
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, n_fail, compares} = 107'h0;
    {wb_sel_i, reread_input_n, rewrite_input_n, rst_n} = 7'h7E;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(bfpb_pkg::OFS_CONFIG, 32'h0, "config");
    rd(bfpb_pkg::OFS_FLAGSEL, {19'h0, bfpb_pkg::FLAGSEL_RST}, "flagsel");
    rd(bfpb_pkg::OFS_LEVEL, bfpb_pkg::LEVEL_RST, "level");
    wb_sel_i <= 4'h1;
    wb(1'b1, bfpb_pkg::OFS_LEVEL, 32'hFFFF_FF03);
    wb_sel_i <= 4'hF;
    rd(bfpb_pkg::OFS_LEVEL, 32'h0008_0003, "level_sel");
    wb(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0, "unmapped");
    chk("strobe_oe", {port_b_read_strobe_n_oe, port_b_write_strobe_n_oe}, 2'h0);
    fl(4'h5);
    $display("test reset done");
    wb(1'b1, bfpb_pkg::OFS_CONFIG, 32'h40);
    wb(1'b1, bfpb_pkg::OFS_CONFIG, 32'h0);
    wb(1'b1, bfpb_pkg::OFS_DATA, 32'h2D1C3);
    fl(4'h4);
    peer_u.pb_rd(b);
    chk("low_byte", b, 9'h1C3);
    peer_u.pb_rd(b);
    chk("high_byte", b, 9'h168);
    @(posedge clk) reread_input_n <= 1'b0;
    @(posedge clk) reread_input_n <= 1'b1;
    peer_u.pb_rd(b);
    chk("reread", b, 9'h1C3);
    wb(1'b1, bfpb_pkg::OFS_CMD, 32'h1);
    fl(4'h5);
    $display("test a_to_b done");
    // A filler word is written, then the rewrite pin winds the write pointer back over it.
    peer_u.pb_wr(9'h1FF);
    peer_u.pb_wr(9'h1FF);
    @(posedge clk) rewrite_input_n <= 1'b0;
    @(posedge clk) rewrite_input_n <= 1'b1;
    @(posedge clk);
    fl(4'h5);
    peer_u.pb_wr(9'h0A5);
    peer_u.pb_wr(9'h13C);
    fl(4'h1);
    rd(bfpb_pkg::OFS_DATA, 32'h278A5, "b_to_a");
    $display("test b_to_a done");
    wb(1'b1, bfpb_pkg::OFS_DATA, 32'h2D1C3);
    wb(1'b1, bfpb_pkg::OFS_CONFIG, 32'h42E);
    @(negedge clk);
    chk("strobe_oe", {port_b_read_strobe_n_oe, port_b_write_strobe_n_oe}, 2'h3);
    chk("ack_idle", port_b_ack_o, 1'b0);
    peer_u.go(1'b1);
    for (n = 0; port_b_ack_o !== 1'b1 && n < 100; n++) @(negedge clk);
    guard(100);
    chk("ack", port_b_ack_o, 1'b1);
    for (n = 0; !(flag_outputs[0] === 1'b1 && port_b_ack_o === 1'b0) && n < 300; n++) @(negedge clk);
    guard(300);
    peer_u.go(1'b0);
    chk("sent", peer_u.cap, 18'h2D0C3);
    chk("rd_strobe", port_b_read_strobe_n_o, 1'b1);
    $display("test peripheral done");
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("strobe_oe", {port_b_read_strobe_n_oe, port_b_write_strobe_n_oe}, 2'h0);
    rd(bfpb_pkg::OFS_CONFIG, 32'h0, "config");
    $display("test second reset done");
    report_and_stop();
  end
endmodule
bind bfpb_port_b bfpb_props #(.FIFO_AW(FIFO_AW)) props_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .port_b_data_oe(port_b_data_oe), .port_b_read_strobe_n_i(port_b_read_strobe_n_i),
  .port_b_read_strobe_n_oe(port_b_read_strobe_n_oe), .port_b_write_strobe_n_o(port_b_write_strobe_n_o),
  .port_b_write_strobe_n_oe(port_b_write_strobe_n_oe), .port_b_clk_i(port_b_clk_i));
`default_nettype wire
